// ### mcd_cmd_decoder.sv
// nine-byte command interpreter for a single motion axis
// assumes bytes arrive on rx_valid/rx_ready and non-volatile storage is
// reached through the nv_* strobes
`timescale 1ns/1ps
`include "mcd_defines.svh"
module mcd_cmd_decoder
	import mcd_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	input wire logic standalone_mode,
	input wire logic [31:0] actual_position,
	input wire logic auto_restore_en,
	input wire logic restore_request,
	input wire logic nv_load_valid,
	input wire logic [7:0] nv_load_index,
	input wire logic [31:0] nv_load_data,
	output logic nv_load_ready,
	output logic nv_restore_req,
	output logic nv_store_valid,
	output logic [7:0] nv_bank,
	output logic [7:0] nv_index,
	output logic [31:0] nv_data,
	output logic move_start,
	output logic [1:0] move_type,
	output logic [31:0] move_value,
	output logic [31:0] max_pos_speed,
	output logic [7:0] module_address,
	output logic [31:0] accu,
	output logic reply_valid,
	output logic [7:0] reply_status,
	output logic [7:0] reply_instr,
	output logic [31:0] reply_value
);

	// =========================================================
	// helpers
	function automatic logic bank_ok(input mcd_byte_t b);
		return b == `MCD_BANK_MODULE || b == `MCD_BANK_USER ||
			b == `MCD_BANK_IRQ;
	endfunction

	mcd_state_e state;
	mcd_byte_t frame [0:8];
	logic [3:0] byte_cnt;
	logic restore_armed;

	mcd_byte_t f_instr, f_type, f_bank;
	mcd_word_t f_value;
	mcd_byte_t csum;
	logic addressed, csum_ok, exec_go;
	logic axis_we, glob_we;
	logic [7:0] axis_addr;
	logic [9:0] glob_addr;
	mcd_word_t axis_rd, glob_rd, ram_wdata;
	logic take;

	assign take = rx_valid && rx_ready;
	assign f_instr = frame[`MCD_IDX_INSTR];
	assign f_type = frame[`MCD_IDX_TYPE];
	assign f_bank = frame[`MCD_IDX_BANK];
	// R16 value msb first
	assign f_value = {frame[4], frame[5], frame[6], frame[7]};

	// R19 checksum sum
	always_comb begin
		csum = 8'h00;
		for (int i = 0; i < 8; i++) begin
			csum = csum + frame[i];
		end
	end
	assign csum_ok = csum == frame[`MCD_IDX_CSUM];
	assign addressed = frame[`MCD_IDX_ADDR] == module_address;
	assign exec_go = state == S_EXEC && addressed && csum_ok;

	// =========================================================
	// parameter memories; the global one is shared with restore loads while idle
	// R03 axis write
	assign axis_we = exec_go && f_instr == `MCD_CMD_SAP && f_bank == 8'h00;
	// R09 global write, banks checked
	// loads only while ready, so nothing lands during reset
	assign glob_we = (exec_go && f_instr == `MCD_CMD_SGP && bank_ok(f_bank))
		|| (state == S_COLLECT && nv_load_valid && nv_load_ready);
	assign axis_addr = f_type;
	// R10 bank selects region
	assign glob_addr = state == S_COLLECT ?
		{2'(`MCD_BANK_USER), nv_load_index} : {f_bank[1:0], f_type};
	assign ram_wdata = state == S_COLLECT ? nv_load_data : f_value;

	// R04 volatile axis store
	mcd_param_ram #(.ADDR_W(8)) u_axis (
		.clock(clock),
		.wr_en(axis_we),
		.addr(axis_addr),
		.wr_data(f_value),
		.rd_data(axis_rd)
	);

	mcd_param_ram #(.ADDR_W(10)) u_glob (
		.clock(clock),
		.wr_en(glob_we),
		.addr(glob_addr),
		.wr_data(ram_wdata),
		.rd_data(glob_rd)
	);

	// =========================================================
	// frame capture
	// R16 nine byte frame
	always_ff @(posedge clock) begin
		if (rst) begin
			byte_cnt <= 4'h0;
			for (int i = 0; i < 9; i++) begin
				frame[i] <= 8'h00;
			end
		end else if (take) begin
			frame[byte_cnt] <= rx_data;
			byte_cnt <= byte_cnt == `MCD_LAST_IDX ? 4'h0 : byte_cnt + 4'h1;
		end
	end

	// =========================================================
	// sequencing; input is stalled while a frame executes
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= S_COLLECT;
			rx_ready <= 1'b0;
			nv_load_ready <= 1'b0;
		end else begin
			unique case (state)
				S_COLLECT: begin
					rx_ready <= 1'b1;
					nv_load_ready <= 1'b1;
					if (take && byte_cnt == `MCD_LAST_IDX) begin
						state <= S_EXEC;
						rx_ready <= 1'b0;
						nv_load_ready <= 1'b0;
					end
				end
				S_EXEC: begin
					// a refused axis read must not reply twice
					if (exec_go && ((f_instr == `MCD_CMD_GAP && f_bank == 8'h00) ||
						(f_instr == `MCD_CMD_GGP && bank_ok(f_bank)) ||
						(f_instr == `MCD_CMD_STORE_GLOBAL_PARAM_CMD && bank_ok(f_bank)))) begin
						state <= S_FETCH;
					end else begin
						state <= S_COLLECT;
						rx_ready <= 1'b1;
						nv_load_ready <= 1'b1;
					end
				end
				S_FETCH: begin
					state <= S_COLLECT;
					rx_ready <= 1'b1;
					nv_load_ready <= 1'b1;
				end
			endcase
		end
	end

	// =========================================================
	// replies
	always_ff @(posedge clock) begin
		if (rst) begin
			reply_valid <= 1'b0;
			reply_status <= 8'h00;
			reply_instr <= 8'h00;
			reply_value <= 32'h0000_0000;
		end else begin
			reply_valid <= 1'b0;
			if (state == S_EXEC && addressed) begin
				reply_instr <= f_instr;
				reply_value <= 32'h0000_0000;
				if (!csum_ok) begin
					// R19 bad checksum refused
					reply_valid <= 1'b1;
					reply_status <= `MCD_ST_BAD_CSUM;
				end else begin
					unique case (f_instr)
						`MCD_CMD_MOVE: begin
							// R18 move types
							reply_valid <= 1'b1;
							reply_status <= f_type > `MCD_MOVE_STORED_COORDINATE_TYPE ?
								`MCD_ST_BAD_TYPE : f_bank != 8'h00 ?
								`MCD_ST_BAD_VALUE : `MCD_ST_OK;
						end
						`MCD_CMD_SAP, `MCD_CMD_GAP: begin
							reply_valid <= f_bank != 8'h00 ||
								f_instr == `MCD_CMD_SAP;
							reply_status <= f_bank != 8'h00 ?
								`MCD_ST_BAD_VALUE : `MCD_ST_OK;
						end
						`MCD_CMD_SGP, `MCD_CMD_GGP, `MCD_CMD_STORE_GLOBAL_PARAM_CMD: begin
							reply_valid <= !bank_ok(f_bank) ||
								f_instr == `MCD_CMD_SGP;
							reply_status <= bank_ok(f_bank) ?
								`MCD_ST_OK : `MCD_ST_BAD_VALUE;
						end
						default: begin
							reply_valid <= 1'b1;
							reply_status <= `MCD_ST_BAD_CMD;
						end
					endcase
				end
			end else if (state == S_FETCH) begin
				// R06 read reply ok plus value
				reply_valid <= 1'b1;
				reply_status <= `MCD_ST_OK;
				if (f_instr == `MCD_CMD_GAP) begin
					// R08 actual position readback
					reply_value <= f_type == `MCD_AP_ACT_POS ?
						actual_position : axis_rd;
				end else if (f_instr == `MCD_CMD_GGP) begin
					reply_value <= glob_rd;
				end
			end
		end
	end

	// =========================================================
	// accumulator
	always_ff @(posedge clock) begin
		if (rst) begin
			accu <= 32'h0000_0000;
		end else if (state == S_FETCH) begin
			// R05 accumulator only standalone
			if (f_instr == `MCD_CMD_GAP && standalone_mode) begin
				accu <= f_type == `MCD_AP_ACT_POS ? actual_position : axis_rd;
			end
			// R12 global read to accumulator
			if (f_instr == `MCD_CMD_GGP) begin
				accu <= glob_rd;
			end
		end
	end

	// =========================================================
	// motion start
	always_ff @(posedge clock) begin
		if (rst) begin
			move_start <= 1'b0;
			move_type <= 2'h0;
			move_value <= 32'h0000_0000;
		end else begin
			move_start <= 1'b0;
			if (exec_go && f_instr == `MCD_CMD_MOVE && f_bank == 8'h00 &&
				f_type <= `MCD_MOVE_STORED_COORDINATE_TYPE) begin
				move_start <= 1'b1;
				move_type <= f_type[1:0];
				// R01 coordinate number from low byte
				move_value <= f_type == `MCD_MOVE_STORED_COORDINATE_TYPE ?
					{24'h00_0000, frame[`MCD_IDX_V0]} : f_value;
			end
		end
	end

	// =========================================================
	// settings mirrored into flops
	always_ff @(posedge clock) begin
		if (rst) begin
			max_pos_speed <= `MCD_RST_MAX_SPEED;
			module_address <= `MCD_RST_SER_ADDR;
		end else begin
			// R07 max positioning speed
			if (axis_we && f_type == `MCD_AP_MAX_SPEED) begin
				max_pos_speed <= f_value;
			end
			// R13 serial address parameter
			if (exec_go && f_instr == `MCD_CMD_SGP &&
				f_bank == `MCD_BANK_MODULE && f_type == `MCD_GP_SER_ADDR) begin
				module_address <= frame[`MCD_IDX_V0];
			end
		end
	end

	// =========================================================
	// non-volatile store and restore requests
	always_ff @(posedge clock) begin
		if (rst) begin
			nv_store_valid <= 1'b0;
			nv_bank <= 8'h00;
			nv_index <= 8'h00;
			nv_data <= 32'h0000_0000;
			nv_restore_req <= 1'b0;
			restore_armed <= 1'b1;
		end else begin
			nv_store_valid <= 1'b0;
			// R15 power-on restore, auto or requested
			nv_restore_req <= (restore_armed && auto_restore_en) ||
				restore_request;
			restore_armed <= 1'b0;
			// R11 bank 0 auto commit
			if (exec_go && f_instr == `MCD_CMD_SGP &&
				f_bank == `MCD_BANK_MODULE) begin
				nv_store_valid <= 1'b1;
				nv_bank <= f_bank;
				nv_index <= f_type;
				nv_data <= f_value;
			end
			// R14 R17 explicit store
			if (state == S_FETCH && f_instr == `MCD_CMD_STORE_GLOBAL_PARAM_CMD) begin
				nv_store_valid <= 1'b1;
				nv_bank <= f_bank;
				nv_index <= f_type;
				nv_data <= glob_rd;
			end
		end
	end

	// =========================================================
	// checks
	property p_stored_coordinate_type;
		@(posedge clock) disable iff (rst)
		exec_go && f_instr == `MCD_CMD_MOVE && f_type == `MCD_MOVE_STORED_COORDINATE_TYPE &&
			f_bank == 8'h00
		|=> move_start && move_type == 2'h2 &&
			move_value == {24'h00_0000, $past(frame[`MCD_IDX_V0])};
	endproperty
	a_stored_coordinate_type: assert property (p_stored_coordinate_type) else $error("stored_coordinate_type move bad"); // R01

	property p_sap;
		@(posedge clock) disable iff (rst)
		exec_go && f_instr == `MCD_CMD_SAP && f_bank == 8'h00
		|=> reply_valid && reply_status == `MCD_ST_OK &&
			u_axis.mem[$past(f_type)] == $past(f_value);
	endproperty
	a_sap: assert property (p_sap) else $error("axis write missed"); // R03

	property p_gap_direct;
		@(posedge clock) disable iff (rst)
		state == S_FETCH && f_instr == `MCD_CMD_GAP && !standalone_mode
		|=> $stable(accu);
	endproperty
	a_gap_direct: assert property (p_gap_direct) else $error("accu moved");
	// R05 tag above

	property p_read_ok;
		@(posedge clock) disable iff (rst)
		state == S_FETCH |=> reply_valid && reply_status == `MCD_ST_OK;
	endproperty
	a_read_ok: assert property (p_read_ok) else $error("read status bad"); // R06

	property p_speed;
		@(posedge clock) disable iff (rst)
		axis_we && f_type == `MCD_AP_MAX_SPEED
		|=> max_pos_speed == $past(f_value);
	endproperty
	a_speed: assert property (p_speed) else $error("speed not held"); // R07

	property p_pos;
		@(posedge clock) disable iff (rst)
		state == S_FETCH && f_instr == `MCD_CMD_GAP &&
			f_type == `MCD_AP_ACT_POS
		|=> reply_value == $past(actual_position);
	endproperty
	a_pos: assert property (p_pos) else $error("position readback bad"); // R08

	property p_bank;
		@(posedge clock) disable iff (rst)
		exec_go && f_instr == `MCD_CMD_SGP && !bank_ok(f_bank)
		|=> reply_valid && reply_status == `MCD_ST_BAD_VALUE;
	endproperty
	a_bank: assert property (p_bank) else $error("bad bank taken"); // R09

	property p_autostore;
		@(posedge clock) disable iff (rst)
		exec_go && f_instr == `MCD_CMD_SGP && f_bank == `MCD_BANK_MODULE
		|=> nv_store_valid && nv_bank == `MCD_BANK_MODULE;
	endproperty
	a_autostore: assert property (p_autostore) else $error("no save"); // R11

	property p_store;
		@(posedge clock) disable iff (rst)
		state == S_FETCH && f_instr == `MCD_CMD_STORE_GLOBAL_PARAM_CMD
		|=> nv_store_valid && nv_data == $past(glob_rd);
	endproperty
	a_store: assert property (p_store) else $error("store missed"); // R17

	property p_csum;
		@(posedge clock) disable iff (rst)
		state == S_EXEC && addressed && !csum_ok
		|=> reply_status == `MCD_ST_BAD_CSUM && !move_start
		##1 !nv_store_valid;
	endproperty
	a_csum: assert property (p_csum) else $error("bad checksum ran"); // R19

	property p_frame;
		@(posedge clock) disable iff (rst)
		take && byte_cnt == `MCD_LAST_IDX |=> state == S_EXEC && !rx_ready;
	endproperty
	a_frame: assert property (p_frame) else $error("frame end missed"); // R16

	c_move: cover property (@(posedge clock) move_start);
	c_read: cover property (@(posedge clock) state == S_FETCH ##1 reply_valid);
	c_store: cover property (@(posedge clock) nv_store_valid);
	c_csum: cover property (@(posedge clock)
		reply_valid && reply_status == `MCD_ST_BAD_CSUM);

endmodule

// ### mcd_defines.svh
// constants of the motion parameter command decoder
// assumes one 125 MHz clock and a byte source that honours rx_ready
//
// Notes on behaviour
// R01: move type 2 moves to the stored coordinate named by value byte 0.
// R02: host must store the coordinate before asking to move to it.
// R03: set-axis-parameter writes the 32-bit value into axis parameter type.
// R04: axis parameters live in volatile storage only.
// R05: get-axis-parameter loads the accumulator only in standalone mode.
// R06: read replies carry status 100 and the value read.
// R07: axis parameter 4 holds maximum positioning speed in pulses per second.
// R08: axis parameter 1 reads back the actual position.
// R09: set-global-parameter writes value into bank 0, 2 or 3 only.
// R10: bank 0 module settings, bank 2 user variables, bank 3 interrupt setup.
// R11: bank 0 writes are committed to non-volatile memory automatically.
// R12: get-global-parameter copies the parameter into the accumulator.
// R13: global parameter 66 of bank 0 is the serial bus address.
// R14: store command saves a global parameter permanently, mainly user variables.
// R15: user variables restored at power on, automatically or on request.
// R16: frame is address, instruction, type, bank, value msb first, checksum.
// R17: store command is instruction 11, parameter chosen by type and bank.
// R18: move type 0 absolute, 1 relative, 2 stored coordinate.
// R19: checksum is 8-bit sum of first eight bytes, checked before execution.
`ifndef MCD_DEFINES_SVH
`define MCD_DEFINES_SVH

// =========================================================
// frame layout
`define MCD_FRAME_LEN 4'h9
`define MCD_LAST_IDX 4'h8
`define MCD_IDX_ADDR 0
`define MCD_IDX_INSTR 1
`define MCD_IDX_TYPE 2
`define MCD_IDX_BANK 3
`define MCD_IDX_V3 4
`define MCD_IDX_V0 7
`define MCD_IDX_CSUM 8

// =========================================================
// instruction codes
`define MCD_CMD_MOVE 8'h04
`define MCD_CMD_SAP 8'h05
`define MCD_CMD_GAP 8'h06
`define MCD_CMD_SGP 8'h09
`define MCD_CMD_GGP 8'h0A
`define MCD_CMD_STORE_GLOBAL_PARAM_CMD 8'h0B

// =========================================================
// move types
`define MCD_MOVE_ABS 8'h00
`define MCD_MOVE_REL 8'h01
`define MCD_MOVE_STORED_COORDINATE_TYPE 8'h02

// =========================================================
// status codes
`define MCD_ST_OK 8'h64
`define MCD_ST_BAD_CSUM 8'h01
`define MCD_ST_BAD_CMD 8'h02
`define MCD_ST_BAD_TYPE 8'h03
`define MCD_ST_BAD_VALUE 8'h04

// =========================================================
// parameter numbers and banks
`define MCD_AP_ACT_POS 8'h01
`define MCD_AP_MAX_SPEED 8'h04
`define MCD_GP_SER_ADDR 8'h42
`define MCD_BANK_MODULE 8'h00
`define MCD_BANK_USER 8'h02
`define MCD_BANK_IRQ 8'h03

// =========================================================
// reset values
`define MCD_RST_SER_ADDR 8'h01
`define MCD_RST_MAX_SPEED 32'h0000_0000

`endif

// ### mcd_pkg.sv
// types shared by the command decoder files
// assumes mcd_defines.svh carries every numeric constant
package mcd_pkg;

	typedef enum logic [1:0] {
		S_COLLECT,
		S_EXEC,
		S_FETCH
	} mcd_state_e;

	typedef logic [31:0] mcd_word_t;
	typedef logic [7:0] mcd_byte_t;

endpackage

// ### mcd_param_ram.sv
// single-port parameter memory with registered read data
// assumes one write or read per cycle; no reset of contents (volatile)
`timescale 1ns/1ps
module mcd_param_ram #(
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wr_data,
	output logic [31:0] rd_data
);

	logic [31:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
		rd_data <= mem[addr];
	end

endmodule

// ### mcd_host_model.sv
// host controller model: sends nine-byte command frames on the byte link
// assumes rx_ready is a register and the caller starts 1 ns after an edge
`timescale 1ns/1ps
module mcd_host_model (
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic clock,
	input wire logic rx_ready
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
	end

	// ==========================================================
	// frame sender
	// nine bytes, msb first
	task automatic send(input logic [7:0] addr, input logic [7:0] instr,
		input logic [7:0] typ, input logic [7:0] bank,
		input logic [31:0] val, input logic bad_sum, output logic ok);
		logic [7:0] f [9];
		int n;
		logic rdy;
		f[0] = addr;
		f[1] = instr;
		f[2] = typ;
		f[3] = bank;
		f[4] = val[31:24];
		f[5] = val[23:16];
		f[6] = val[15:8];
		f[7] = val[7:0];
		f[8] = 8'h00;
		for (int i = 0; i < 8; i++) begin
			f[8] = f[8] + f[i];
		end
		// a corrupt sum flips the lowest bit only
		f[8] = f[8] ^ {7'h00, bad_sum};
		ok = 1'b1;
		for (int i = 0; i < 9; i++) begin
			rx_valid = 1'b1;
			rx_data = f[i];
			n = 0;
			// ready is a register: its value before the edge is what counts
			do begin
				rdy = rx_ready;
				@(posedge clock);
				#1;
				n++;
			end while (rdy !== 1'b1 && n < 40);
			if (rdy !== 1'b1) begin
				ok = 1'b0;
			end
		end
		rx_valid = 1'b0;
		// released line shows no stale byte
		rx_data = ~f[8];
	endtask
endmodule

// ### tb_top.sv
// self-checking bench for the motion parameter command decoder
// assumes the host model drives the byte link, bench drives all else
`timescale 1ns/1ps
`include "mcd_defines.svh"
module tb_top
	import mcd_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic rx_valid, rx_ready, standalone_mode, auto_restore_en;
	logic restore_request, nv_load_valid, nv_load_ready, nv_restore_req;
	logic nv_store_valid, move_start, reply_valid;
	logic [7:0] rx_data, nv_load_index, nv_bank, nv_index, module_address;
	logic [7:0] reply_status, reply_instr;
	logic [1:0] move_type;
	logic [31:0] actual_position, nv_load_data, nv_data, move_value;
	logic [31:0] max_pos_speed, accu, reply_value;
	logic [7:0] dev_addr = 8'h01;
	logic got_move, got_store;
	int n_errors = 0;
	int n_compared = 0;

	always #4 clock = ~clock;

	mcd_host_model host_u (.clock(clock), .rx_ready(rx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data));

	mcd_cmd_decoder dut_u (.clock(clock), .rst(rst), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready),
		.standalone_mode(standalone_mode), .actual_position(actual_position),
		.auto_restore_en(auto_restore_en), .restore_request(restore_request),
		.nv_load_valid(nv_load_valid), .nv_load_index(nv_load_index),
		.nv_load_data(nv_load_data), .nv_load_ready(nv_load_ready),
		.nv_restore_req(nv_restore_req), .nv_store_valid(nv_store_valid),
		.nv_bank(nv_bank), .nv_index(nv_index), .nv_data(nv_data),
		.move_start(move_start), .move_type(move_type),
		.move_value(move_value), .max_pos_speed(max_pos_speed),
		.module_address(module_address), .accu(accu),
		.reply_valid(reply_valid), .reply_status(reply_status),
		.reply_instr(reply_instr), .reply_value(reply_value));

	// ==========================================================
	// shared tasks
	task automatic stop_test();
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	// lat is the cycle after the ninth byte edge in which the reply stands
	task automatic cmd(input logic [7:0] instr, input logic [7:0] typ,
		input logic [7:0] bank, input logic [31:0] val,
		input logic [7:0] st, input int lat, input logic bad);
		logic ok;
		int n;
		host_u.send(dev_addr, instr, typ, bank, val, bad, ok);
		chk("frame_taken", 32'h1, {31'h0, ok});
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (reply_valid !== 1'b1 && n < 6);
		if (reply_valid !== 1'b1) begin
			chk("reply_valid", 32'h1, {31'h0, reply_valid});
			stop_test();
		end
		got_move = move_start;
		got_store = nv_store_valid;
		chk("reply_latency", 32'(lat), 32'(n + 1));
		chk("reply_status", {24'h0, st}, {24'h0, reply_status});
		chk("reply_instr", {24'h0, instr}, {24'h0, reply_instr});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		@(posedge clock);
		#1;
		chk("nv_restore_req", 32'h1, {31'h0, nv_restore_req});
		chk("rx_ready", 32'h1, {31'h0, rx_ready});
		chk("nv_load_ready", 32'h1, {31'h0, nv_load_ready});
		chk("module_address", 32'h1, {24'h0, module_address});
		chk("max_pos_speed", 32'h0, max_pos_speed);
		chk("accu", 32'h0, accu);
		@(posedge clock);
		#1;
		chk("nv_restore_req", 32'h0, {31'h0, nv_restore_req});
	endtask

	task automatic t_axis();
		cmd(`MCD_CMD_SAP, `MCD_AP_MAX_SPEED, 8'h00, 32'h0000C800,
			`MCD_ST_OK, 2, 0);
		chk("max_pos_speed", 32'h0000C800, max_pos_speed);
		cmd(`MCD_CMD_GAP, `MCD_AP_MAX_SPEED, 8'h00, 32'h0,
			`MCD_ST_OK, 3, 0);
		chk("reply_value", 32'h0000C800, reply_value);
		chk("accu", 32'h0, accu);
		actual_position = 32'h12345678;
		standalone_mode = 1'b1;
		cmd(`MCD_CMD_GAP, `MCD_AP_ACT_POS, 8'h00, 32'h0,
			`MCD_ST_OK, 3, 0);
		chk("reply_value", 32'h12345678, reply_value);
		chk("accu", 32'h12345678, accu);
		standalone_mode = 1'b0;
	endtask

	task automatic t_global();
		cmd(`MCD_CMD_SGP, 8'h07, `MCD_BANK_USER, 32'hCAFE0001,
			`MCD_ST_OK, 2, 0);
		chk("nv_store_valid", 32'h0, {31'h0, got_store});
		cmd(`MCD_CMD_SGP, 8'h07, `MCD_BANK_IRQ, 32'h00000077,
			`MCD_ST_OK, 2, 0);
		cmd(`MCD_CMD_SGP, 8'h07, 8'h01, 32'h00000011,
			`MCD_ST_BAD_VALUE, 2, 0);
		cmd(`MCD_CMD_GGP, 8'h07, `MCD_BANK_USER, 32'hFFFFFFFF,
			`MCD_ST_OK, 3, 0);
		chk("reply_value", 32'hCAFE0001, reply_value);
		chk("accu", 32'hCAFE0001, accu);
		cmd(`MCD_CMD_GGP, 8'h07, `MCD_BANK_IRQ, 32'h0,
			`MCD_ST_OK, 3, 0);
		chk("accu", 32'h00000077, accu);
		cmd(`MCD_CMD_STORE_GLOBAL_PARAM_CMD, 8'h07, `MCD_BANK_USER, 32'h0,
			`MCD_ST_OK, 3, 0);
		chk("nv_store_valid", 32'h1, {31'h0, got_store});
		chk("nv_store", 32'h0207CAFE,
			{nv_bank, nv_index, nv_data[31:16]});
		chk("nv_data", 32'hCAFE0001, nv_data);
		cmd(`MCD_CMD_SGP, `MCD_GP_SER_ADDR, `MCD_BANK_MODULE, 32'h3,
			`MCD_ST_OK, 2, 0);
		chk("nv_store_valid", 32'h1, {31'h0, got_store});
		chk("nv_store", 32'h00420003,
			{nv_bank, nv_index, nv_data[15:0]});
		chk("module_address", 32'h3, {24'h0, module_address});
		dev_addr = 8'h03;
		cmd(`MCD_CMD_GGP, `MCD_GP_SER_ADDR, `MCD_BANK_MODULE, 32'h0,
			`MCD_ST_OK, 3, 0);
		chk("reply_value", 32'h3, reply_value);
	endtask

	task automatic t_move();
		logic [31:0] vals [3] = '{32'h00015F90, 32'hFFFFD8F0, 32'h00000008};
		for (int t = 0; t < 3; t++) begin
			cmd(`MCD_CMD_MOVE, 8'(t), 8'h00, vals[t], `MCD_ST_OK, 2, 0);
			chk("move_start", 32'h1, {31'h0, got_move});
			chk("move_type", 32'(t), {30'h0, move_type});
			chk("move_value", vals[t], move_value);
		end
		cmd(`MCD_CMD_MOVE, 8'h03, 8'h00, 32'h1, `MCD_ST_BAD_TYPE, 2, 0);
		chk("move_start", 32'h0, {31'h0, got_move});
	endtask

	task automatic t_errors();
		logic ok;
		cmd(`MCD_CMD_SAP, `MCD_AP_MAX_SPEED, 8'h00, 32'h1,
			`MCD_ST_BAD_CSUM, 2, 1);
		chk("max_pos_speed", 32'h0000C800, max_pos_speed);
		cmd(8'h01, 8'h00, 8'h00, 32'h0, `MCD_ST_BAD_CMD, 2, 0);
		// frame for another address must stay silent
		host_u.send(8'h01, `MCD_CMD_SAP, `MCD_AP_MAX_SPEED, 8'h00, 32'h5,
			1'b0, ok);
		repeat (6) begin
			@(posedge clock);
			#1;
			chk("reply_valid", 32'h0, {31'h0, reply_valid});
		end
		chk("max_pos_speed", 32'h0000C800, max_pos_speed);
	endtask

	task automatic t_nvload();
		int n;
		logic rdy;
		nv_load_index = 8'h09;
		nv_load_data = 32'h5A5A0009;
		nv_load_valid = 1'b1;
		n = 0;
		do begin
			rdy = nv_load_ready;
			@(posedge clock);
			#1;
			n++;
		end while (rdy !== 1'b1 && n < 20);
		nv_load_valid = 1'b0;
		chk("nv_load_taken", 32'h1, {31'h0, rdy});
		cmd(`MCD_CMD_GGP, 8'h09, `MCD_BANK_USER, 32'h0,
			`MCD_ST_OK, 3, 0);
		chk("reply_value", 32'h5A5A0009, reply_value);
		restore_request = 1'b1;
		@(posedge clock);
		#1;
		restore_request = 1'b0;
		n = 0;
		while (nv_restore_req !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("nv_restore_req", 32'h1, {31'h0, nv_restore_req});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		standalone_mode = 1'b0;
		actual_position = 32'h0;
		auto_restore_en = 1'b1;
		restore_request = 1'b0;
		nv_load_valid = 1'b0;
		nv_load_index = 8'h00;
		nv_load_data = 32'h0;
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		t_reset();
		t_axis();
		t_global();
		t_move();
		t_errors();
		t_nvload();
		stop_test();
	end
endmodule
